// [common/sstx_defines.vh]
`ifndef SSTX_DEFINES_VH
`define SSTX_DEFINES_VH
`define SSTX_OFF_CTRL 8'h00
`define SSTX_OFF_DATA 8'h04
`define SSTX_OFF_BAUD 8'h08
`define SSTX_OFF_FIFO 8'h0C
`define SSTX_BIT_CLKSRC 7
`define SSTX_BIT_NINE 6
`define SSTX_BIT_TRANSMIT_ENABLE_BIT 5
`define SSTX_BIT_SYNC 4
`define SSTX_BIT_UNIMP 3
`define SSTX_BIT_SPEED 2
`define SSTX_BIT_EMPTY 1
`define SSTX_BIT_D9 0
`define SSTX_CTRL_RESET 8'h02
`define SSTX_BAUD_RESET 8'h00
`define SSTX_MULT_LOW 12'h010
`define SSTX_MULT_HIGH 12'h004
`define SSTX_FIFO_DEPTH 4
`define SSTX_FIFO_WIDTH 9
`endif

// [rtl/sstx_fifo.v]
module sstx_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire reset,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointers wrap naturally because the depth is a power of two.
	always @(posedge clk) begin
		if (reset) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end
endmodule

// [rtl/sstx_top.v]
// The register addresses and the APB slave port are this design's own decisions.
`include "sstx_defines.vh"

module sstx_top (
	input wire CLK,
	input wire RESET,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	output reg TX_CK_O,
	output reg TX_CK_OE,
	input wire TX_CK_I,
	output reg DT_O,
	output reg DT_OE
);
	localparam ST_IDLE = 2'b00;
	localparam ST_START = 2'b01;
	localparam ST_DATA = 2'b10;
	localparam ST_STOP = 2'b11;

	reg clock_source_select_reg;
	reg nine_bit_transmit_select_reg;
	reg transmit_enable_bit_reg;
	reg sync_mode_reg;
	reg baud_speed_select_reg;
	reg ninth_transmit_bit_reg;
	reg [7:0] baud_div_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [8:0] transmit_shift_register_reg;
	reg [3:0] bit_cnt_reg;
	reg [11:0] tick_cnt_reg;
	reg phase_reg;
	reg ck_s1_reg;
	reg ck_s2_reg;
	reg ck_s3_reg;
	reg line_next;
	reg ck_next;
	wire [7:0] ctrl_read;
	wire [11:0] tick_limit;
	wire tick;
	wire slave_fall;
	wire step;
	wire access;
	wire complete;
	wire mapped;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [8:0] fifo_out_data;
	wire push_data;
	wire is_master;
	wire is_slave;
	wire busy;
	wire last_bit;

	function [11:0] bit_period;
		input [7:0] div;
		input sync_mode;
		input speed;
		reg [11:0] base;
		reg [23:0] prod;
		begin
			base = {4'h0, div} + 12'h001;
			prod = 24'h000000;
			if (sync_mode) begin
				bit_period = base;
			end else begin
				if (speed) begin
					prod = base * `SSTX_MULT_HIGH;
				end else begin
					prod = base * `SSTX_MULT_LOW;
				end
				// The largest low-speed period wraps to zero, and the
				// counter then runs its full span, which is the same length.
				bit_period = prod[11:0];
			end
		end
	endfunction

	function is_mapped;
		input [7:0] addr;
		begin
			is_mapped = (addr == `SSTX_OFF_CTRL) ||
				(addr == `SSTX_OFF_DATA) ||
				(addr == `SSTX_OFF_BAUD) ||
				(addr == `SSTX_OFF_FIFO);
		end
	endfunction

	// The flag reflects the shift register, not the FIFO, so software can
	// tell when the last character has fully left the line.
	assign busy = (state_reg != ST_IDLE);
	assign ctrl_read = {clock_source_select_reg, nine_bit_transmit_select_reg,
		transmit_enable_bit_reg, sync_mode_reg, 1'b0,
		baud_speed_select_reg, ~busy, ninth_transmit_bit_reg};

	assign access = PSEL & PENABLE & ~PREADY;
	assign complete = PSEL & PENABLE & PREADY;
	assign mapped = is_mapped(PADDR);
	assign push_data = complete & PWRITE & (PADDR == `SSTX_OFF_DATA);

	always @(posedge CLK) begin
		if (RESET) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			PREADY <= access;
			PSLVERR <= access & ~mapped;
			PRDATA <= 32'h00000000;
			if (access & ~PWRITE) begin
				case (PADDR)
				`SSTX_OFF_CTRL: PRDATA <= {24'h000000, ctrl_read};
				`SSTX_OFF_BAUD: PRDATA <= {24'h000000, baud_div_reg};
				`SSTX_OFF_FIFO: PRDATA <= {30'h00000000, ~fifo_out_valid,
					~fifo_in_ready};
				default: PRDATA <= 32'h00000000;
				endcase
			end
		end
	end

	always @(posedge CLK) begin
		if (RESET) begin
			clock_source_select_reg <= 1'b0;
			nine_bit_transmit_select_reg <= 1'b0;
			transmit_enable_bit_reg <= 1'b0;
			sync_mode_reg <= 1'b0;
			baud_speed_select_reg <= 1'b0;
			ninth_transmit_bit_reg <= 1'b0;
			baud_div_reg <= `SSTX_BAUD_RESET;
		end else if (complete & PWRITE) begin
			if (PADDR == `SSTX_OFF_CTRL) begin
				clock_source_select_reg <= PWDATA[`SSTX_BIT_CLKSRC];
				nine_bit_transmit_select_reg <= PWDATA[`SSTX_BIT_NINE];
				transmit_enable_bit_reg <= PWDATA[`SSTX_BIT_TRANSMIT_ENABLE_BIT];
				sync_mode_reg <= PWDATA[`SSTX_BIT_SYNC];
				baud_speed_select_reg <= PWDATA[`SSTX_BIT_SPEED];
				ninth_transmit_bit_reg <= PWDATA[`SSTX_BIT_D9];
			end
			if (PADDR == `SSTX_OFF_BAUD) begin
				baud_div_reg <= PWDATA[7:0];
			end
		end
	end

	// The ninth bit is captured with the character, which is why it must
	// already sit in the control register when the data word is written.
	sstx_fifo #(
		.WIDTH(`SSTX_FIFO_WIDTH),
		.DEPTH(`SSTX_FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.clk(CLK),
		.reset(RESET),
		.in_valid(push_data),
		.in_ready(fifo_in_ready),
		.in_data({ninth_transmit_bit_reg, PWDATA[7:0]}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign is_master = sync_mode_reg & clock_source_select_reg;
	assign is_slave = sync_mode_reg & ~clock_source_select_reg;
	assign fifo_out_ready = (state_reg == ST_IDLE) & transmit_enable_bit_reg;

	always @(posedge CLK) begin
		if (RESET) begin
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
			ck_s3_reg <= 1'b0;
		end else begin
			ck_s1_reg <= TX_CK_I;
			ck_s2_reg <= ck_s1_reg;
			ck_s3_reg <= ck_s2_reg;
		end
	end

	assign slave_fall = ck_s3_reg & ~ck_s2_reg;
	assign tick_limit = bit_period(baud_div_reg, sync_mode_reg,
		baud_speed_select_reg);
	assign tick = (tick_cnt_reg == tick_limit - 12'h001);
	assign step = is_slave ? slave_fall :
		(is_master ? (tick & phase_reg) : tick);
	assign last_bit = (bit_cnt_reg == (nine_bit_transmit_select_reg ?
		4'h8 : 4'h7));

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (fifo_out_valid & fifo_out_ready) begin
				state_next = sync_mode_reg ? ST_DATA : ST_START;
			end
		end
		ST_START: begin
			if (step) begin
				state_next = ST_DATA;
			end
		end
		ST_DATA: begin
			if (step & last_bit) begin
				state_next = sync_mode_reg ? ST_IDLE : ST_STOP;
			end
		end
		ST_STOP: begin
			if (step) begin
				state_next = ST_IDLE;
			end
		end
		default: state_next = ST_IDLE;
		endcase
		if (~transmit_enable_bit_reg) begin
			state_next = ST_IDLE;
		end
	end

	always @(posedge CLK) begin
		if (RESET) begin
			state_reg <= ST_IDLE;
			transmit_shift_register_reg <= 9'h000;
			bit_cnt_reg <= 4'h0;
			tick_cnt_reg <= 12'h000;
			phase_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE || tick) begin
				tick_cnt_reg <= 12'h000;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 12'h001;
			end
			if (state_reg == ST_IDLE) begin
				phase_reg <= 1'b0;
			end else if (tick) begin
				phase_reg <= ~phase_reg;
			end
			if (fifo_out_valid & fifo_out_ready) begin
				transmit_shift_register_reg <= fifo_out_data;
				bit_cnt_reg <= 4'h0;
			end else if (state_reg == ST_DATA && step) begin
				transmit_shift_register_reg <= {1'b0,
					transmit_shift_register_reg[8:1]};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	always @* begin
		case (state_reg)
		ST_START: line_next = 1'b0;
		ST_DATA: line_next = transmit_shift_register_reg[0];
		default: line_next = 1'b1;
		endcase
		ck_next = is_master & (state_reg == ST_DATA) & phase_reg;
	end

	// Pins are registered, so they trail the state by one clock.
	always @(posedge CLK) begin
		if (RESET) begin
			TX_CK_O <= 1'b1;
			TX_CK_OE <= 1'b0;
			DT_O <= 1'b1;
			DT_OE <= 1'b0;
		end else begin
			TX_CK_O <= sync_mode_reg ? ck_next : line_next;
			TX_CK_OE <= transmit_enable_bit_reg &
				(~sync_mode_reg | clock_source_select_reg);
			DT_O <= line_next;
			DT_OE <= transmit_enable_bit_reg & sync_mode_reg & busy;
		end
	end
endmodule

// [testbench/sstx_assertions.sv]
module sstx_assertions (
	input wire CLK,
	input wire RESET,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [31:0] PRDATA,
	input wire PREADY,
	input wire PSLVERR,
	input wire TX_CK_O,
	input wire TX_CK_OE,
	input wire DT_OE
);
	timeunit 1ns;
	timeprecision 1ps;
	// Shadow of the control byte, captured at the same edge as the design.
	logic [7:0] ctl;
	always @(posedge CLK) begin
		if (RESET)
			ctl <= 8'h00;
		else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00)
			ctl <= PWDATA[7:0];
	end
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RESET);
	chk_ready_wait: assert property (PSEL && $rose(PENABLE) |=> PREADY)
		else $error("late ready");
	chk_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	chk_err_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("error data");
	chk_bit3_zero: assert property (PREADY && !PWRITE && PADDR == 8'h00
		|-> PRDATA[3] == 1'b0 && PRDATA[31:8] == 24'h0) else $error("bit3");
	chk_tx_off: assert property (!ctl[5] |=> !TX_CK_OE && !DT_OE)
		else $error("driven while off");
	chk_async_on: assert property (ctl[5] && !ctl[4] |=> TX_CK_OE)
		else $error("async pin off");
	chk_async_nodt: assert property (!ctl[4] |=> !DT_OE)
		else $error("data pin in async");
	chk_master_clk: assert property (ctl[5] && ctl[4] && ctl[7] |=> TX_CK_OE)
		else $error("master clock off");
	chk_slave_clk: assert property (ctl[5] && ctl[4] && !ctl[7] |=> !TX_CK_OE)
		else $error("slave drives clock");
	chk_reset_idle: assert property (disable iff (1'b0)
		RESET |=> !PREADY && !TX_CK_OE && !DT_OE) else $error("reset");
	cover property (PSLVERR);
	cover property ($fell(TX_CK_O) && !ctl[4]);
	cover property (ctl[5] && ctl[4] && ctl[7]);
endmodule

// [testbench/sstx_partner.sv]
module sstx_partner (
	input wire clk,
	input wire line,
	input int per,
	input wire nine,
	output logic ck,
	output logic [8:0] rx,
	output logic stb
);
	timeunit 1ns;
	timeprecision 1ps;
	// Async listener only; the slave clock idles high, so slave mode stalls.
	initial begin
		ck = 1'b1;
		stb = 1'b0;
		rx = 9'h000;
		forever begin
			@(negedge line);
			repeat (per / 2) @(posedge clk);
			rx = 9'h000;
			for (int i = 0; i < (nine ? 9 : 8); i++) begin
				repeat (per) @(posedge clk);
				rx[i] = line;
			end
			repeat (per) @(posedge clk);
			stb = 1'b1;
			@(posedge clk);
			stb = 1'b0;
		end
	end
endmodule

// [testbench/tb_second_serial_port_tx_control.sv]
`include "sstx_defines.vh"

module tb_second_serial_port_tx_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h00000000;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, TX_CK_O, TX_CK_OE, DT_O, DT_OE, ck, stb;
	wire [8:0] rx;
	// Pull-up on the pin: a released line reads high.
	wire line = TX_CK_OE ? TX_CK_O : 1'b1;
	int per = 32;
	logic nine = 1'b0;
	logic [8:0] expq[$];
	logic [31:0] lf = 32'h0000A084;
	logic [31:0] r;
	int error_cnt = 0;
	int checks = 0;

	sstx_top i_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .TX_CK_O(TX_CK_O),
		.TX_CK_OE(TX_CK_OE), .TX_CK_I(ck), .DT_O(DT_O), .DT_OE(DT_OE));
	sstx_partner i_far (.clk(CLK), .line(line), .per(per), .nine(nine),
		.ck(ck), .rx(rx), .stb(stb));

	always #2.5 CLK = ~CLK;

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1);
		chk("pready", 32'h1, {31'h0, PREADY});
		chk("pslverr", {31'h0, a > 8'h0C}, {31'h0, PSLVERR});
		r = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("read", e, r);
	endtask

	task automatic drain(input logic [31:0] e);
		for (int n = 0; n < 5000 && expq.size() > 0; n++)
			@(posedge CLK);
		repeat (per) @(posedge CLK);
		chk("dt_idle", 32'h1, {31'h0, DT_O});
		rd(`SSTX_OFF_CTRL, e);
	endtask

	always @(posedge stb)
		chk("frame", expq.size() ? expq.pop_front() : 'x, rx);

	initial begin
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		rd(`SSTX_OFF_CTRL, 32'h02);
		apb(1'b1, `SSTX_OFF_CTRL, 32'hDD);
		rd(`SSTX_OFF_CTRL, 32'hD7);
		apb(1'b0, 8'h10, 32'h0);
		apb(1'b1, `SSTX_OFF_BAUD, 32'h01);
		apb(1'b1, `SSTX_OFF_CTRL, 32'h00);
		for (int i = 0; i < 5; i++) begin
			lf = lfsr(lf);
			apb(1'b1, `SSTX_OFF_DATA, {24'h0, lf[7:0]});
			// The fifth word meets a full buffer and is dropped.
			if (i < 4)
				expq.push_back({1'b0, lf[7:0]});
		end
		rd(`SSTX_OFF_FIFO, 32'h1);
		apb(1'b1, `SSTX_OFF_CTRL, 32'h20);
		rd(`SSTX_OFF_CTRL, 32'h20);
		drain(32'h22);
		per = 8;
		nine = 1'b1;
		apb(1'b1, `SSTX_OFF_CTRL, 32'h65);
		for (int i = 0; i < 3; i++) begin
			lf = lfsr(lf);
			apb(1'b1, `SSTX_OFF_DATA, {24'h0, lf[7:0]});
			expq.push_back({i < 2, lf[7:0]});
			if (i == 1)
				apb(1'b1, `SSTX_OFF_CTRL, 32'h64);
		end
		drain(32'h66);
		rd(`SSTX_OFF_FIFO, 32'h2);
		apb(1'b1, `SSTX_OFF_CTRL, 32'h30);
		apb(1'b1, `SSTX_OFF_CTRL, 32'hB0);
		repeat (4) @(posedge CLK);
		report_and_stop();
	end

	// Whole run needs under 3000 cycles; this catches a stuck handshake.
	initial begin
		repeat (20000) @(posedge CLK);
		error_cnt++;
		report_and_stop();
	end
endmodule

bind sstx_top sstx_assertions i_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TX_CK_O(TX_CK_O), .TX_CK_OE(TX_CK_OE), .DT_OE(DT_OE));
